// [sdpfs_regs.svh]
`ifndef SDPFS_REGS_SVH
`define SDPFS_REGS_SVH

// Register byte offsets
`define SDPFS_ADDR_FUNC 8'h00
`define SDPFS_ADDR_PORT_OUT 8'h04
`define SDPFS_ADDR_PORT_DIR 8'h08
`define SDPFS_ADDR_PIN_IN 8'h0C
`define SDPFS_ADDR_STATUS 8'h10

// Reset values
`define SDPFS_FUNC_RST 24'h000000
`define SDPFS_PORT_RST 18'h00000
`define SDPFS_RDATA_RST 32'h00000000

// Geometry: six groups of three pins, four config bits per group
`define SDPFS_NPIN 18
`define SDPFS_NCFG 24
`define SDPFS_NGRP 6
`define SDPFS_NSER 4
`define SDPFS_NDMA 2
`define SDPFS_GRP_PINS 3
`define SDPFS_GRP_W 4
`define SDPFS_G_SER2 0
`define SDPFS_G_SER5 3
`define SDPFS_G_DMA0 4
`define SDPFS_G_DMA2 5
`define SDPFS_PIN(g, p) ((g) * `SDPFS_GRP_PINS + (p))
`define SDPFS_CFG(g, f) ((g) * `SDPFS_GRP_W + (f))

// Pin position inside a group
`define SDPFS_P_RX 0
`define SDPFS_P_TX 1
`define SDPFS_P_CK 2
`define SDPFS_P_REQ 0
`define SDPFS_P_ACK 1
`define SDPFS_P_ES 2

// Config bit inside a group
`define SDPFS_F_TX_EN 0
`define SDPFS_F_CK_OUT 1
`define SDPFS_F_CK_EXT 2
`define SDPFS_F_REQ_SEL 0
`define SDPFS_F_ACK_EN 1
`define SDPFS_F_END_EN 2
`define SDPFS_F_STOP_EN 3

// Synchroniser vector layout: pins, mode straps, interrupt
`define SDPFS_SYNC_W 22
`define SDPFS_SYNC_MODE_LSB 18
`define SDPFS_SYNC_MODE_MSB 20
`define SDPFS_SYNC_NMI 21
`define SDPFS_STATUS_NMI 3

// Edges after reset release before strap levels are settled
`define SDPFS_STRAP_W 3
`define SDPFS_STRAP_WAIT 3'h4
`define SDPFS_STRAP_ZERO 3'h0
`define SDPFS_STRAP_ONE 3'h1

`endif

// [sdpfs_pkg.sv]
package sdpfs_pkg;

    // Signals driven by the on-chip peripherals towards the pins
    typedef struct packed {
        logic [3:0] ser_txd;
        logic [3:0] ser_sck;
        logic [1:0] dma_ack;
        logic [1:0] dma_end;
    } sdpfs_drv_t;

    // Signals handed from the pins to the on-chip peripherals
    typedef struct packed {
        logic [3:0] ser_rxd;
        logic [3:0] ser_sck;
        logic [1:0] dma_req;
        logic [1:0] dma_stop;
        logic [2:0] mode;
        logic nmi;
    } sdpfs_rcv_t;

endpackage

// [sdpfs_sync.sv]
module sdpfs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // A bit moves only once stages two and three agree
            q <= (s2_r & s3_r) | (q & (s2_r | s3_r));
        end
    end
endmodule

// [sdpfs_pin_cell.sv]
module sdpfs_pin_cell (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic func_drive,
    input wire logic func_val,
    input wire logic port_val,
    input wire logic port_dir,
    output logic pin_out,
    output logic pin_oe_b
);
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pin_out <= 1'b0;
            pin_oe_b <= 1'b1;
        end else begin
            // Alternate output wins; otherwise the port bit owns the driver
            pin_out <= func_drive ? func_val : port_val;
            pin_oe_b <= !(func_drive || port_dir);
        end
    end
endmodule

// [sdpfs_pin_select.sv]
`include "sdpfs_regs.svh"

// Behaviour
// - Async serial transmit pin drives data only while transmit output enabled, else port.
// - Async serial clock pin is clock when clock output enabled or external clock.
// - Serial clock pin is port only with no external clock and output off; code gives it to port whenever clock output off.
// - Clocked serial data pin drives shifted data only while its output enabled.
// - Clocked serial clock pin is shift clock in external mode or output enabled.
// - DMA request pin counts only when selected start source; port output kept off, which code leaves to the port direction bit.
// - DMA acknowledge pin outputs accept indication only while enabled, else port.
// - DMA end/stop pin drives completion while transfer end output enabled.
// - Same pin accepts stop when stop input enabled; port only when both off, but code gives it to port whenever end output off.
// - Three mode-select pins are decoded to set the basic operating mode.
// - Interrupt pin is a non-maskable request that no masking can disable.
// - Dedicated external reset input initialises the whole block.
module sdpfs_pin_select
    import sdpfs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] address,
    input wire logic [3:0] byteenable,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [`SDPFS_NPIN-1:0] pin_in,
    output logic [`SDPFS_NPIN-1:0] pin_out,
    output logic [`SDPFS_NPIN-1:0] pin_oe_b,
    input wire logic [2:0] mode_pin_in,
    input wire logic nmi_pin_in,
    input wire sdpfs_drv_t periph_drv,
    output sdpfs_rcv_t periph_rcv
);
    logic [`SDPFS_NCFG-1:0] func_r;
    logic [`SDPFS_NPIN-1:0] port_out_r;
    logic [`SDPFS_NPIN-1:0] port_dir_r;
    logic [2:0] mode_r;
    logic [`SDPFS_STRAP_W-1:0] strap_cnt_r;
    logic strap_done_r;
    logic cfg_touched_r;
    logic [`SDPFS_SYNC_W-1:0] sync_q;
    logic [`SDPFS_NPIN-1:0] pins_s;
    logic [`SDPFS_NPIN-1:0] fdrive;
    logic [`SDPFS_NPIN-1:0] fval;
    logic [31:0] func_w;
    logic [31:0] port_out_w;
    logic [31:0] port_dir_w;
    logic [31:0] rdata_nxt;
    logic wr_take;
    logic rd_take;
    sdpfs_rcv_t rcv_nxt;

    function automatic logic [31:0] be_merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [31:0] widen(input logic [`SDPFS_NCFG-1:0] v);
        return {{(32 - `SDPFS_NCFG){1'b0}}, v};
    endfunction

    function automatic logic [31:0] widen_p(input logic [`SDPFS_NPIN-1:0] v);
        return {{(32 - `SDPFS_NPIN){1'b0}}, v};
    endfunction

    // Pins, mode straps and the interrupt all arrive from outside the clock domain
    sdpfs_sync #(
        .WIDTH(`SDPFS_SYNC_W)
    ) u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .d({nmi_pin_in, mode_pin_in, pin_in}),
        .q(sync_q)
    );

    assign pins_s = sync_q[`SDPFS_NPIN-1:0];

    // One wait state: a request is answered at the second edge it is seen
    assign wr_take = write && !waitrequest;
    assign rd_take = read && waitrequest;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
        end
    end

    assign func_w = be_merge(widen(func_r), writedata, byteenable);
    assign port_out_w = be_merge(widen_p(port_out_r), writedata, byteenable);
    assign port_dir_w = be_merge(widen_p(port_dir_r), writedata, byteenable);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            func_r <= `SDPFS_FUNC_RST;
            port_out_r <= `SDPFS_PORT_RST;
            port_dir_r <= `SDPFS_PORT_RST;
            cfg_touched_r <= 1'b0;
        end else if (wr_take) begin
            cfg_touched_r <= 1'b1;
            case (address)
                `SDPFS_ADDR_FUNC: func_r <= func_w[`SDPFS_NCFG-1:0];
                `SDPFS_ADDR_PORT_OUT: port_out_r <= port_out_w[`SDPFS_NPIN-1:0];
                `SDPFS_ADDR_PORT_DIR: port_dir_r <= port_dir_w[`SDPFS_NPIN-1:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        case (address)
            `SDPFS_ADDR_FUNC: rdata_nxt = widen(func_r);
            `SDPFS_ADDR_PORT_OUT: rdata_nxt = widen_p(port_out_r);
            `SDPFS_ADDR_PORT_DIR: rdata_nxt = widen_p(port_dir_r);
            `SDPFS_ADDR_PIN_IN: rdata_nxt = widen_p(pins_s);
            `SDPFS_ADDR_STATUS: rdata_nxt = {28'h0000000, sync_q[`SDPFS_SYNC_NMI], mode_r};
            default: rdata_nxt = `SDPFS_RDATA_RST;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            readdata <= `SDPFS_RDATA_RST;
        end else if (rd_take) begin
            readdata <= rdata_nxt;
        end
    end

    // straps caught once settled after release, then frozen
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            strap_cnt_r <= `SDPFS_STRAP_ZERO;
            strap_done_r <= 1'b0;
            mode_r <= 3'h0;
        end else if (!strap_done_r) begin
            if (strap_cnt_r == `SDPFS_STRAP_WAIT) begin
                mode_r <= sync_q[`SDPFS_SYNC_MODE_MSB:`SDPFS_SYNC_MODE_LSB];
                strap_done_r <= 1'b1;
            end else begin
                strap_cnt_r <= strap_cnt_r + `SDPFS_STRAP_ONE;
            end
        end
    end

    // Which alternate function drives each pin
    always_comb begin
        fdrive = '0;
        fval = '0;
        for (int g = 0; g < `SDPFS_NSER; g++) begin
            fdrive[`SDPFS_PIN(g, `SDPFS_P_TX)] = func_r[`SDPFS_CFG(g, `SDPFS_F_TX_EN)];
            fval[`SDPFS_PIN(g, `SDPFS_P_TX)] = periph_drv.ser_txd[g];
            fdrive[`SDPFS_PIN(g, `SDPFS_P_CK)] = func_r[`SDPFS_CFG(g, `SDPFS_F_CK_OUT)];
            fval[`SDPFS_PIN(g, `SDPFS_P_CK)] = periph_drv.ser_sck[g];
        end
        for (int d = 0; d < `SDPFS_NDMA; d++) begin
            fdrive[`SDPFS_PIN(`SDPFS_G_DMA0 + d, `SDPFS_P_ACK)] =
                func_r[`SDPFS_CFG(`SDPFS_G_DMA0 + d, `SDPFS_F_ACK_EN)];
            fval[`SDPFS_PIN(`SDPFS_G_DMA0 + d, `SDPFS_P_ACK)] = periph_drv.dma_ack[d];
            fdrive[`SDPFS_PIN(`SDPFS_G_DMA0 + d, `SDPFS_P_ES)] =
                func_r[`SDPFS_CFG(`SDPFS_G_DMA0 + d, `SDPFS_F_END_EN)];
            fval[`SDPFS_PIN(`SDPFS_G_DMA0 + d, `SDPFS_P_ES)] = periph_drv.dma_end[d];
        end
    end

    // Input functions never switch the driver: leave that to software
    for (genvar p = 0; p < `SDPFS_NPIN; p++) begin : g_pin
        sdpfs_pin_cell u_cell (
            .clock(clock),
            .rst_b(rst_b),
            .func_drive(fdrive[p]),
            .func_val(fval[p]),
            .port_val(port_out_r[p]),
            .port_dir(port_dir_r[p]),
            .pin_out(pin_out[p]),
            .pin_oe_b(pin_oe_b[p])
        );
    end

    // Inputs handed to peripherals; an unselected source reads as idle low
    always_comb begin
        rcv_nxt = '0;
        for (int g = 0; g < `SDPFS_NSER; g++) begin
            rcv_nxt.ser_rxd[g] = pins_s[`SDPFS_PIN(g, `SDPFS_P_RX)];
            rcv_nxt.ser_sck[g] = func_r[`SDPFS_CFG(g, `SDPFS_F_CK_EXT)] &&
                pins_s[`SDPFS_PIN(g, `SDPFS_P_CK)];
        end
        for (int d = 0; d < `SDPFS_NDMA; d++) begin
            rcv_nxt.dma_req[d] = func_r[`SDPFS_CFG(`SDPFS_G_DMA0 + d, `SDPFS_F_REQ_SEL)] &&
                pins_s[`SDPFS_PIN(`SDPFS_G_DMA0 + d, `SDPFS_P_REQ)];
            rcv_nxt.dma_stop[d] = func_r[`SDPFS_CFG(`SDPFS_G_DMA0 + d, `SDPFS_F_STOP_EN)] &&
                pins_s[`SDPFS_PIN(`SDPFS_G_DMA0 + d, `SDPFS_P_ES)];
        end
        rcv_nxt.mode = mode_r;
        // no mask exists on this path
        rcv_nxt.nmi = sync_q[`SDPFS_SYNC_NMI];
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            periph_rcv <= '0;
        end else begin
            periph_rcv <= rcv_nxt;
        end
    end

    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    bus_one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered after one wait state");

    serial_tx_drive_a: assert property (
        func_r[`SDPFS_CFG(`SDPFS_G_SER2, `SDPFS_F_TX_EN)] |=>
            !pin_oe_b[`SDPFS_PIN(`SDPFS_G_SER2, `SDPFS_P_TX)] &&
            pin_out[`SDPFS_PIN(`SDPFS_G_SER2, `SDPFS_P_TX)] == $past(periph_drv.ser_txd[0]))
        else $error("serial transmit pin not carrying data");

    serial_ext_clock_a: assert property (
        periph_rcv.ser_sck[0] |-> $past(func_r[`SDPFS_CFG(`SDPFS_G_SER2, `SDPFS_F_CK_EXT)]))
        else $error("external serial clock passed while not selected");

    serial_ck_port_a: assert property (
        !func_r[`SDPFS_CFG(`SDPFS_G_SER2, `SDPFS_F_CK_OUT)] &&
            !port_dir_r[`SDPFS_PIN(`SDPFS_G_SER2, `SDPFS_P_CK)] |=>
            pin_oe_b[`SDPFS_PIN(`SDPFS_G_SER2, `SDPFS_P_CK)])
        else $error("serial clock pin driven as neither clock nor port");

    shift_data_out_a: assert property (
        !func_r[`SDPFS_CFG(`SDPFS_G_SER5, `SDPFS_F_TX_EN)] |=>
            pin_out[`SDPFS_PIN(`SDPFS_G_SER5, `SDPFS_P_TX)] ==
            $past(port_out_r[`SDPFS_PIN(`SDPFS_G_SER5, `SDPFS_P_TX)]))
        else $error("shift data pin not acting as port bit");

    shift_clock_out_a: assert property (
        func_r[`SDPFS_CFG(`SDPFS_G_SER5, `SDPFS_F_CK_OUT)] |=>
            !pin_oe_b[`SDPFS_PIN(`SDPFS_G_SER5, `SDPFS_P_CK)] &&
            pin_out[`SDPFS_PIN(`SDPFS_G_SER5, `SDPFS_P_CK)] == $past(periph_drv.ser_sck[3]))
        else $error("shift clock not driven on pin");

    dma_req_gate_a: assert property (
        periph_rcv.dma_req[0] |->
            $past(func_r[`SDPFS_CFG(`SDPFS_G_DMA0, `SDPFS_F_REQ_SEL)]))
        else $error("transfer request seen while not start source");

    dma_accept_out_a: assert property (
        func_r[`SDPFS_CFG(`SDPFS_G_DMA0, `SDPFS_F_ACK_EN)] |=>
            !pin_oe_b[`SDPFS_PIN(`SDPFS_G_DMA0, `SDPFS_P_ACK)] &&
            pin_out[`SDPFS_PIN(`SDPFS_G_DMA0, `SDPFS_P_ACK)] == $past(periph_drv.dma_ack[0]))
        else $error("accept indication not on pin");

    dma_done_out_a: assert property (
        func_r[`SDPFS_CFG(`SDPFS_G_DMA2, `SDPFS_F_END_EN)] |=>
            !pin_oe_b[`SDPFS_PIN(`SDPFS_G_DMA2, `SDPFS_P_ES)] &&
            pin_out[`SDPFS_PIN(`SDPFS_G_DMA2, `SDPFS_P_ES)] == $past(periph_drv.dma_end[1]))
        else $error("completion indication not on pin");

    dma_halt_in_a: assert property (
        periph_rcv.dma_stop[1] |->
            $past(func_r[`SDPFS_CFG(`SDPFS_G_DMA2, `SDPFS_F_STOP_EN)]))
        else $error("stop request passed while stop input off");

    // The output register trails the capture by one edge, so wait for it first
    mode_frozen_a: assert property (
        strap_done_r && $past(strap_done_r) |=> $stable(periph_rcv.mode))
        else $error("operating mode changed after capture");

    nmi_follow_a: assert property ($stable(nmi_pin_in) [*6] |-> periph_rcv.nmi == nmi_pin_in)
        else $error("interrupt request not following its pin");

    reset_port_a: assert property (!cfg_touched_r |-> &pin_oe_b)
        else $error("pin driven before any configuration");

endmodule

// [sdpfs_far_side.sv]
module sdpfs_far_side
    import sdpfs_pkg::*;
#(
    parameter logic [2:0] STRAP = 3'h5
) (
    input wire logic [17:0] ext_val,
    input wire logic nmi_level,
    input wire logic [17:0] pin_out,
    input wire logic [17:0] pin_oe_b,
    output logic [17:0] pin_in,
    output logic [2:0] mode_pin_in,
    output logic nmi_pin_in
);
    // far devices drive only released pins
    // Every released pin is held, so no level is left to the simulator
    assign pin_in = (pin_oe_b & ext_val) | (~pin_oe_b & pin_out);
    // straps tied to one fixed level
    assign mode_pin_in = STRAP;
    // interrupt line driven as a plain level
    assign nmi_pin_in = nmi_level;
endmodule

// [serial_dma_pin_function_select_bench.sv]
`include "sdpfs_regs.svh"

module serial_dma_pin_function_select_bench
    import sdpfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [2:0] STRAP = 3'h5;
    localparam int IN_PINS = 32'h09249;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] address = 8'h00;
    logic [3:0] byteenable = 4'hF;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [31:0] readdata;
    logic waitrequest;
    logic [17:0] pin_in;
    logic [17:0] pin_out;
    logic [17:0] pin_oe_b;
    logic [17:0] ext_val = 18'h00000;
    logic [2:0] mode_pin_in;
    logic nmi_pin_in;
    logic nmi_level = 1'b0;
    sdpfs_drv_t periph_drv = '0;
    sdpfs_rcv_t periph_rcv;
    int error_cnt = 0;
    int checks = 0;
    int seed = 37558;
    int m_func = 0;
    int m_pout = 0;
    int m_pdir = 0;

    always #50 clock = ~clock;

    sdpfs_pin_select i_dut (.clock(clock), .rst_b(rst_b), .address(address),
        .byteenable(byteenable), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_b(pin_oe_b), .mode_pin_in(mode_pin_in),
        .nmi_pin_in(nmi_pin_in), .periph_drv(periph_drv), .periph_rcv(periph_rcv));

    sdpfs_far_side #(.STRAP(STRAP)) i_far (.ext_val(ext_val), .nmi_level(nmi_level),
        .pin_out(pin_out), .pin_oe_b(pin_oe_b), .pin_in(pin_in),
        .mode_pin_in(mode_pin_in), .nmi_pin_in(nmi_pin_in));

    task automatic end_of_test();
        if (error_cnt == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Holds the request until waitrequest is sampled low at an edge
    task automatic av_wait();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (waitrequest !== 1'b0) begin
            error_cnt++;
            $display("mismatch waitrequest expected 0 seen %b", waitrequest);
            end_of_test();
        end
    endtask

    function automatic int merge(int old, int d, logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                old[8*i+:8] = d[8*i+:8];
            end
        end
        return old;
    endfunction

    task automatic av_write(input logic [7:0] a, input int d, input logic [3:0] be);
        @(posedge clock);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= 1'b1;
        av_wait();
        write <= 1'b0;
        if (a == `SDPFS_ADDR_FUNC) begin
            m_func = merge(m_func, d, be) & 32'h00FFFFFF;
        end else if (a == `SDPFS_ADDR_PORT_OUT) begin
            m_pout = merge(m_pout, d, be) & 32'h0003FFFF;
        end else if (a == `SDPFS_ADDR_PORT_DIR) begin
            m_pdir = merge(m_pdir, d, be) & 32'h0003FFFF;
        end
    endtask

    task automatic av_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        address <= a;
        read <= 1'b1;
        av_wait();
        d = readdata;
        read <= 1'b0;
    endtask

    task automatic check_regs();
        logic [31:0] rd;
        int exp[3];
        exp = '{m_func, m_pout, m_pdir};
        for (int i = 0; i < 3; i++) begin
            av_read(8'(4 * i), rd);
            chk("register", 32'(exp[i]), rd);
        end
        av_read(8'h14, rd);
        chk("unmapped", 32'h00000000, rd);
    endtask

    task automatic check_all();
        logic [17:0] drv;
        logic [17:0] val;
        logic [17:0] eoe_b;
        logic [17:0] eo;
        logic [17:0] lvl;
        logic [31:0] rd;
        sdpfs_rcv_t er;
        drv = '0;
        val = '0;
        er = '0;
        for (int g = 0; g < 6; g++) begin
            drv[3*g+1] = (g < 4) ? m_func[4*g] : m_func[4*g+1];
            drv[3*g+2] = (g < 4) ? m_func[4*g+1] : m_func[4*g+2];
            if (g < 4) begin
                val[3*g+1] = periph_drv.ser_txd[g];
                val[3*g+2] = periph_drv.ser_sck[g];
            end else begin
                val[3*g+1] = periph_drv.dma_ack[g-4];
                val[3*g+2] = periph_drv.dma_end[g-4];
            end
        end
        eoe_b = ~(drv | 18'(m_pdir));
        eo = (val & drv) | (18'(m_pout) & ~drv);
        lvl = (eo & ~eoe_b) | (ext_val & eoe_b);
        for (int g = 0; g < 6; g++) begin
            if (g < 4) begin
                er.ser_rxd[g] = lvl[3*g];
                er.ser_sck[g] = m_func[4*g+2] & lvl[3*g+2];
            end else begin
                er.dma_req[g-4] = m_func[4*g] & lvl[3*g];
                er.dma_stop[g-4] = m_func[4*g+3] & lvl[3*g+2];
            end
        end
        er.mode = STRAP;
        er.nmi = nmi_level;
        chk("pin_oe_b", 32'(eoe_b), 32'(pin_oe_b));
        chk("pin_out", 32'(eo), 32'(pin_out));
        chk("periph_rcv", 32'(er), 32'(periph_rcv));
        av_read(`SDPFS_ADDR_PIN_IN, rd);
        chk("pin_in_reg", 32'(lvl), rd);
        av_read(`SDPFS_ADDR_STATUS, rd);
        chk("status", {28'h0000000, nmi_level, STRAP}, rd);
    endtask

    initial begin
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        repeat (8) @(posedge clock);
        check_all();
        check_regs();
        for (int it = 0; it < 48; it++) begin
            periph_drv <= sdpfs_drv_t'(12'($random(seed)));
            ext_val <= 18'($random(seed));
            nmi_level <= 1'($random(seed));
            av_write(`SDPFS_ADDR_FUNC, $random(seed), 4'hF);
            av_write(`SDPFS_ADDR_PORT_OUT, $random(seed), 4'($random(seed)));
            // port drivers stay off on input pins
            av_write(`SDPFS_ADDR_PORT_DIR, $random(seed) & ~IN_PINS, 4'hF);
            av_write(8'h14, $random(seed), 4'hF);
            repeat (8) @(posedge clock);
            check_all();
            check_regs();
        end
        // reset in mid-run returns every pin to port use
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        m_func = 0;
        m_pout = 0;
        m_pdir = 0;
        repeat (8) @(posedge clock);
        check_all();
        check_regs();
        end_of_test();
    end
endmodule
